// ### rtl/txd_decode.sv
/*
  Transmit context and extended data descriptor decoder.
  Assumes the fetch engine presents one descriptor at a time with a
  valid/ready handshake, reports data fetch completion, and accepts
  a status write-back request with a valid/ready handshake.
*/
// Behaviour
// - Extended descriptor with type 0 is a context descriptor.
// - Extended descriptor with type 1 is a data descriptor; software sets the flag.
// - Context command byte bits decoded as documented layout.
// - IP bit one means IPv4; L4 bit one means TCP.
// - Without segmentation SNAP is masked in a context; IP and L4 bits load the checksum context.
// - Report plus delay write-back loads countdown; zero raises interrupt if enabled.
// - Every delayed write-back reloads the countdown even while running.
// - Report without delay interrupts at once and clears the countdown.
// - Status write-back is never held for interrupt delay, only bursting.
// - Done flag written after fetch completes, only when report is set.
// - Null address or zero length moves no data yet still reports.
// - SNAP bit marks the segmentation header as holding SNAP to update.
// - Context descriptor replaces segmentation or checksum parameters at once.
// - Data command byte bits decoded as documented layout.
// - VLAN insert forces CRC and tag; otherwise CRC follows append bit.
// - Segmentation bit selects segmentation context; software then requests CRC.
// - VLAN, CRC and tag sampled from first segment or last descriptor.
// - Last descriptor flag closes the packet's descriptor chain.
// - Options byte read from first data descriptor; bits request checksums.
// - Cleared checksum bit leaves software's checksum field untouched.
`timescale 1ns/1ps
module txd_decode
  import txd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [txd_pkg::DESC_W-1:0] tx_descriptor,
  input wire logic desc_valid,
  output logic desc_ready,
  output logic fetch_req,
  output logic [63:0] fetch_addr,
  output logic [15:0] fetch_len,
  input wire logic fetch_done,
  output logic wb_valid,
  output logic [3:0] wb_status,
  input wire logic wb_ready,
  input wire logic writeback_burst_enable,
  input wire logic writeback_irq_enable,
  input wire logic [15:0] tx_irq_delay_reg,
  input wire logic [15:0] vlan_ethertype_reg,
  output logic tx_irq,
  output logic irq_delay_running,
  output logic desc_bad,
  output logic seg_active,
  output logic seg_ipv4,
  output logic seg_tcp,
  output logic seg_snap,
  output logic csum_ipv4,
  output logic csum_tcp,
  output logic pkt_start,
  output logic pkt_last,
  output logic pkt_seg,
  output logic vlan_insert_enable,
  output logic crc_append_enable,
  output logic [15:0] vlan_tag,
  output logic [15:0] vlan_ethertype,
  output logic l4_checksum_insert,
  output logic ip_checksum_insert
);
  import txd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  txd_state_type state_ff;
  txd_state_type nxt_state;
  txd_ctx_if ctx ();

  function automatic logic cmd_bit(input logic [7:0] cmd, input int pos);
    cmd_bit = cmd[pos];
  endfunction

  wire [7:0] context_command_byte = tx_descriptor[CMD_LSB +: 8];
  wire [7:0] data_command_byte = tx_descriptor[CMD_LSB +: 8];
  wire [7:0] packet_options_byte = tx_descriptor[OPT_LSB +: 8];
  wire [TYPE_W-1:0] descriptor_type_field = tx_descriptor[TYPE_LSB +: TYPE_W];
  wire extended_format_flag = tx_descriptor[EXT_BIT];
  wire [LEN_W-1:0] buffer_length_field = tx_descriptor[LEN_LSB +: LEN_W];
  wire [ADDR_W-1:0] buf_addr = tx_descriptor[ADDR_LSB +: ADDR_W];
  wire [TAG_W-1:0] tag_field = tx_descriptor[TAG_LSB +: TAG_W];

  wire is_ctx = extended_format_flag && descriptor_type_field == TYPE_CONTEXT;
  wire is_data = extended_format_flag && descriptor_type_field == TYPE_DATA;
  wire take = desc_valid && desc_ready;

  // Context fields: with non-core bits masked when segmentation is off
  wire ctx_tse = cmd_bit(context_command_byte, CMD_TSE);
  wire ctx_ide = cmd_bit(context_command_byte, CMD_IDE);
  wire ctx_rs = cmd_bit(context_command_byte, CMD_RS);
  wire ctx_snap = ctx_tse && cmd_bit(context_command_byte, CMD_SNAP);
  wire ctx_ipv4 = ctx_tse && cmd_bit(context_command_byte, CMD_IPV4);
  wire ctx_tcp = ctx_tse && cmd_bit(context_command_byte, CMD_TCP);

  // Data fields
  wire d_ide = cmd_bit(data_command_byte, CMD_IDE);
  wire d_vle = cmd_bit(data_command_byte, CMD_VLE);
  wire d_rs = cmd_bit(data_command_byte, CMD_RS);
  wire d_tse = cmd_bit(data_command_byte, CMD_TSE);
  wire d_crc = cmd_bit(data_command_byte, CMD_CRC);
  wire d_last = cmd_bit(data_command_byte, CMD_LAST);

  wire cur_ide = is_ctx ? ctx_ide : d_ide;
  wire cur_rs = is_ctx ? ctx_rs : d_rs;
  // Zero address or length skips the fetch entirely
  wire no_data = is_ctx || buf_addr == 64'h0 || buffer_length_field == 16'h0;

  ////////////////////////////////////////////////////////////////////////////

  logic rs_ff;
  logic ide_ff;
  logic in_pkt_ff;
  logic seg_first_ff;

  // First data descriptor of a packet opens it; the options byte counts there
  wire first_desc = take && is_data && !in_pkt_ff;
  // Segmenting: sample from first descriptor; otherwise from the last one
  wire sample_l2 = take && is_data &&
                   (d_tse ? (seg_first_ff || !in_pkt_ff) : d_last);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TXD_IDLE: begin
        if (take && is_data && !no_data) begin
          nxt_state = TXD_FETCH;
        end else if (take && (is_ctx || is_data) && cur_rs) begin
          nxt_state = TXD_WBACK;
        end
      end
      TXD_FETCH: begin
        if (fetch_done) begin
          nxt_state = rs_ff ? TXD_WBACK : TXD_IDLE;
        end
      end
      TXD_WBACK: begin
        if (wb_ready) begin
          nxt_state = TXD_IDLE;
        end
      end
      default: nxt_state = TXD_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= TXD_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rs_ff <= 1'b0;
      ide_ff <= 1'b0;
      fetch_addr <= 64'h0;
      fetch_len <= 16'h0;
    end else if (take) begin
      rs_ff <= cur_rs;
      ide_ff <= cur_ide;
      fetch_addr <= buf_addr;
      fetch_len <= buffer_length_field;
    end
  end

  // Context replaced the moment it is taken, no wait on packet end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seg_active <= 1'b0;
      seg_ipv4 <= 1'b0;
      seg_tcp <= 1'b0;
      seg_snap <= 1'b0;
      csum_ipv4 <= 1'b0;
      csum_tcp <= 1'b0;
    end else if (take && is_ctx) begin
      if (ctx_tse) begin
        seg_active <= 1'b1;
        seg_ipv4 <= ctx_ipv4;
        seg_tcp <= ctx_tcp;
        seg_snap <= ctx_snap;
      end else begin
        csum_ipv4 <= cmd_bit(context_command_byte, CMD_IPV4);
        csum_tcp <= cmd_bit(context_command_byte, CMD_TCP);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_pkt_ff <= 1'b0;
      seg_first_ff <= 1'b0;
      pkt_start <= 1'b0;
      pkt_last <= 1'b0;
      pkt_seg <= 1'b0;
    end else begin
      pkt_start <= first_desc;
      pkt_last <= take && is_data && d_last;
      if (take && is_ctx && ctx_tse) begin
        seg_first_ff <= 1'b1;
      end else if (take && is_data && d_tse) begin
        seg_first_ff <= 1'b0;
      end
      if (take && is_data) begin
        in_pkt_ff <= !d_last;
        pkt_seg <= d_tse;
      end
    end
  end

  // Options fields outside bits 1:0 are dropped here
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      l4_checksum_insert <= 1'b0;
      ip_checksum_insert <= 1'b0;
      vlan_insert_enable <= 1'b0;
      crc_append_enable <= 1'b0;
      vlan_tag <= 16'h0;
      vlan_ethertype <= 16'h0;
    end else begin
      if (first_desc) begin
        // Clear bits leave the packet's checksum field as software wrote it
        l4_checksum_insert <= packet_options_byte[OPT_L4];
        ip_checksum_insert <= packet_options_byte[OPT_IP];
      end
      if (sample_l2) begin
        vlan_insert_enable <= d_vle;
        crc_append_enable <= d_vle || d_crc;
        vlan_tag <= d_vle ? tag_field : 16'h0;
        vlan_ethertype <= vlan_ethertype_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Descriptors neither context nor data are consumed and flagged
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      desc_bad <= 1'b0;
    end else begin
      desc_bad <= take && !is_ctx && !is_data;
    end
  end

  assign desc_ready = (state_ff == TXD_IDLE);
  assign fetch_req = (state_ff == TXD_FETCH);
  // Write-back waits only on the bus ready and the burst hold, never the timer
  assign wb_valid = (state_ff == TXD_WBACK) && !writeback_burst_enable;
  assign wb_status = (state_ff == TXD_WBACK) ? STATUS_DONE : STATUS_NONE;

  assign ctx.wb_pulse = wb_valid && wb_ready;
  assign ctx.wb_ide = ide_ff;
  assign ctx.delay_value = tx_irq_delay_reg;
  assign tx_irq = ctx.irq_pulse;

  txd_irq_delay u_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .writeback_irq_enable(writeback_irq_enable),
    .ctx(ctx),
    .delay_running(irq_delay_running)
  );

  ////////////////////////////////////////////////////////////////////////////

  chk_ctx_decode: assert property (@(posedge clk) disable iff (sys_rst)
    take && is_ctx && ctx_tse |=> seg_active && seg_tcp == $past(ctx_tcp)
      && seg_ipv4 == $past(ctx_ipv4)) else $error("context not applied");
  chk_done_only_rs: assert property (@(posedge clk) disable iff (sys_rst)
    wb_valid |-> rs_ff && wb_status == STATUS_DONE) else $error("done without report");
  chk_fetch_then_wb: assert property (@(posedge clk) disable iff (sys_rst)
    fetch_req && fetch_done && rs_ff |=> state_ff == TXD_WBACK)
    else $error("no write-back after fetch");
  chk_null_no_fetch: assert property (@(posedge clk) disable iff (sys_rst)
    take && no_data |=> !fetch_req) else $error("null buffer fetched");
  chk_vlan_crc: assert property (@(posedge clk) disable iff (sys_rst)
    vlan_insert_enable |-> crc_append_enable) else $error("vlan without crc");
  chk_sample_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !sample_l2 |=> $stable(vlan_tag) && $stable(crc_append_enable))
    else $error("l2 fields changed");
  chk_last_closes: assert property (@(posedge clk) disable iff (sys_rst)
    take && is_data && d_last |=> pkt_last && !in_pkt_ff) else $error("packet not closed");
  chk_opts_first: assert property (@(posedge clk) disable iff (sys_rst)
    !first_desc |=> $stable(l4_checksum_insert) && $stable(ip_checksum_insert))
    else $error("options outside first");
  chk_snap_masked: assert property (@(posedge clk) disable iff (sys_rst)
    take && is_ctx && !ctx_tse |=> $stable(seg_snap)) else $error("snap used without seg");

  // Outcomes one cycle after a take; each antecedent is reached by an ordinary descriptor
  chk_data_fetch: assert property (@(posedge clk) disable iff (sys_rst)
    take && is_data && !no_data |=> fetch_req)
    else $error("data buffer not fetched");
  chk_csum_context: assert property (@(posedge clk) disable iff (sys_rst)
    take && is_ctx && !ctx_tse |=> csum_ipv4 == $past(context_command_byte[CMD_IPV4])
      && csum_tcp == $past(context_command_byte[CMD_TCP])) else $error("checksum ctx lost");
  chk_bad_type: assert property (@(posedge clk) disable iff (sys_rst)
    take && !is_ctx && !is_data |=> desc_bad && !fetch_req && !wb_valid)
    else $error("unknown type acted on");
  chk_plain_crc: assert property (@(posedge clk) disable iff (sys_rst)
    sample_l2 && !d_vle |=> crc_append_enable == $past(d_crc) && !vlan_insert_enable)
    else $error("plain frame crc wrong");
  chk_tag_taken: assert property (@(posedge clk) disable iff (sys_rst)
    sample_l2 && d_vle |=> vlan_tag == $past(tag_field) && crc_append_enable)
    else $error("vlan tag not sampled");
endmodule

// ### rtl/txd_pkg.sv
/*
  Constants for the transmit descriptor decoder: descriptor field positions,
  type codes, command and option bit positions, and decoder state encodings.
  Assumes a 128-bit descriptor presented whole by the fetch engine.
*/
package txd_pkg;

  localparam int DESC_W = 128;
  // Second qword layout: length [15:0], type [23:20], command [31:24],
  // status [35:32], options [47:40], tag [63:48]
  localparam int LEN_LSB = 64;
  localparam int LEN_W = 16;
  localparam int TYPE_LSB = 84;
  localparam int TYPE_W = 4;
  localparam int CMD_LSB = 88;
  localparam int OPT_LSB = 104;
  localparam int TAG_LSB = 112;
  localparam int TAG_W = 16;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 64;
  localparam int EXT_BIT = 93;

  localparam logic [TYPE_W-1:0] TYPE_CONTEXT = 4'h0;
  localparam logic [TYPE_W-1:0] TYPE_DATA = 4'h1;

  // Command byte bit positions, shared by context and data formats
  localparam int CMD_IDE = 7;
  localparam int CMD_SNAP = 6;
  localparam int CMD_VLE = 6;
  localparam int CMD_EXT = 5;
  localparam int CMD_RS = 3;
  localparam int CMD_TSE = 2;
  localparam int CMD_IPV4 = 1;
  localparam int CMD_CRC = 1;
  localparam int CMD_TCP = 0;
  localparam int CMD_LAST = 0;

  localparam int OPT_L4 = 1;
  localparam int OPT_IP = 0;

  localparam logic [3:0] STATUS_DONE = 4'h1;
  localparam logic [3:0] STATUS_NONE = 4'h0;

  localparam int DELAY_W = 16;
  localparam logic [DELAY_W-1:0] DELAY_ZERO = 16'h0000;
  localparam logic [DELAY_W-1:0] DELAY_ONE = 16'h0001;

  typedef enum logic [2:0] {
    TXD_IDLE = 3'b001,
    TXD_FETCH = 3'b010,
    TXD_WBACK = 3'b100
  } txd_state_type;

endpackage

// ### rtl/txd_ctx_if.sv
/*
  Interface carrying write-back pulses, the delay flag and the delay value from the
  decoder to its interrupt delay unit, and the interrupt pulse back. Assumes one clock domain.
*/
`timescale 1ns/1ps
interface txd_ctx_if;
  logic wb_pulse;
  logic wb_ide;
  logic [15:0] delay_value;
  logic irq_pulse;

  modport decoder (output wb_pulse, output wb_ide, output delay_value, input irq_pulse);
  modport timer (input wb_pulse, input wb_ide, input delay_value, output irq_pulse);
endinterface

// ### rtl/txd_irq_delay.sv
/*
  Transmit interrupt delay countdown. Assumes write-back pulses from the
  decoder and a write-back interrupt enable level from the same clock.
*/
`timescale 1ns/1ps
module txd_irq_delay
  import txd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic writeback_irq_enable,
  txd_ctx_if.timer ctx,
  output logic delay_running
);
  import txd_pkg::*;

  logic [DELAY_W-1:0] count_ff;
  logic [DELAY_W-1:0] nxt_count;
  logic irq_ff;
  logic nxt_irq;
  wire expire = (count_ff == DELAY_ONE);
  wire immediate = ctx.wb_pulse && !ctx.wb_ide;
  wire reload = ctx.wb_pulse && ctx.wb_ide;

  // Reload wins over a running count so a later descriptor restarts it
  assign nxt_count = reload ? ctx.delay_value :
                     immediate ? DELAY_ZERO :
                     (count_ff != DELAY_ZERO) ? count_ff - DELAY_ONE : DELAY_ZERO;
  // A zero delay value behaves as an immediate interrupt
  assign nxt_irq = writeback_irq_enable &&
                   (immediate || (reload && ctx.delay_value == DELAY_ZERO) ||
                    (!reload && expire));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= DELAY_ZERO;
      irq_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      irq_ff <= nxt_irq;
    end
  end

  assign ctx.irq_pulse = irq_ff;
  assign delay_running = (count_ff != DELAY_ZERO);

  chk_reload_loads: assert property (@(posedge clk) disable iff (sys_rst)
    reload |=> count_ff == $past(ctx.delay_value)) else $error("delay not reloaded");
  chk_immediate_irq: assert property (@(posedge clk) disable iff (sys_rst)
    immediate && writeback_irq_enable |=> irq_ff && count_ff == DELAY_ZERO)
    else $error("immediate irq missing");
  chk_expire_irq: assert property (@(posedge clk) disable iff (sys_rst)
    expire && !reload && !ctx.wb_pulse && writeback_irq_enable |=> irq_ff)
    else $error("expiry irq missing");
endmodule

// ### dv/txd_host_model.sv
/*
  Host side model for the descriptor decoder: completes data fetches and
  accepts status write-backs, promptly or after a stall.
  Assumes the decoder holds each request until it is answered.
*/
`timescale 1ns/1ps
module txd_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic fetch_req,
  output logic fetch_done,
  input wire logic wb_valid,
  input wire logic [3:0] wb_status,
  output logic wb_ready,
  output int wb_count,
  output int bad_status
);
  import txd_pkg::*;
  int wait_cnt;
  // Counts start at zero and survive a reset so the bench can compare across one
  always @(negedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_done <= 1'b0;
      wb_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (fetch_done || wb_ready) begin
      // Answers last one cycle only
      fetch_done <= 1'b0;
      wb_ready <= 1'b0;
    end else if (fetch_req || wb_valid) begin
      if (wait_cnt < (slow ? 6 : 0)) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        fetch_done <= fetch_req;
        wb_ready <= wb_valid && !fetch_req;
        if (wb_valid && !fetch_req) begin
          wb_count <= wb_count + 1;
          bad_status <= bad_status + int'(wb_status !== STATUS_DONE);
        end
      end
    end
  end
endmodule

// ### dv/txd_decode_tb.sv
/*
  Self-checking bench for the descriptor decoder: a table of single
  descriptors, then interrupt delay, bursting, stall and reset cases.
  Assumes the host model answers fetches and write-backs.
*/
`timescale 1ns/1ps
module txd_decode_tb;
  import txd_pkg::*;
  typedef struct {
    logic [3:0] t;
    logic [7:0] cmd;
    logic [7:0] opt;
    logic [63:0] adr;
    logic [15:0] len;
    logic [15:0] tag;
    logic [9:0] ev;
    logic [6:0] ctl;
    logic [15:0] etag;
  } txd_row_type;
  localparam int DLY = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [DESC_W-1:0] tx_descriptor = '0;
  logic desc_valid = 1'b0;
  logic writeback_burst_enable = 1'b0;
  logic writeback_irq_enable = 1'b1;
  logic [15:0] tx_irq_delay_reg = 16'h0000;
  logic [15:0] vlan_ethertype_reg = 16'h9a5c;
  logic slow = 1'b0;
  logic desc_ready, fetch_req, fetch_done, wb_valid, wb_ready, tx_irq, irq_delay_running;
  logic desc_bad, seg_ipv4, seg_tcp, seg_snap, pkt_last, vlan_insert_enable;
  logic crc_append_enable, l4_checksum_insert, ip_checksum_insert, seg_active, csum_ipv4;
  logic csum_tcp, pkt_start, pkt_seg;
  logic [63:0] fetch_addr, seen_addr;
  logic [15:0] fetch_len, vlan_tag, vlan_ethertype, seen_len;
  logic [3:0] wb_status;
  logic prev_req = 1'b0;
  int wb_count, bad_status, n_fetch = 0, n_irq = 0, n_bad = 0, n_last = 0, cyc = 0;
  int n_start = 0;
  int failures = 0;
  int check_count = 0;
  int snap[5];
  // Lengths stay far below any transmit FIFO size; ext flag set in every row
  txd_row_type rows [11] = '{
    '{4'h0, 8'h67, 8'h00, 64'h0, 16'h0, 16'h0, 10'h000, 7'h70, 16'h0},
    '{4'h0, 8'h6b, 8'h00, 64'h0, 16'h0, 16'h0, 10'h050, 7'h70, 16'h0},
    '{4'h0, 8'h24, 8'h00, 64'h0, 16'h0, 16'h0, 10'h000, 7'h00, 16'h0},
    '{4'h1, 8'h7e, 8'hff, 64'h1000_0040, 16'h40, 16'h1234, 10'h150, 7'h0f, 16'h1234},
    '{4'h1, 8'h25, 8'h00, 64'h1000_0080, 16'h20, 16'h5678, 10'h101, 7'h0f, 16'h1234},
    '{4'h1, 8'h60, 8'h01, 64'h2000_0000, 16'h30, 16'h1111, 10'h100, 7'h0d, 16'h1234},
    '{4'h1, 8'h29, 8'h02, 64'h2000_0030, 16'h10, 16'h2222, 10'h151, 7'h01, 16'h0},
    '{4'h1, 8'h61, 8'h00, 64'h3000_0000, 16'h40, 16'h3333, 10'h101, 7'h0c, 16'h3333},
    '{4'h1, 8'h2b, 8'h03, 64'h0, 16'h10, 16'h0, 10'h051, 7'h07, 16'h0},
    '{4'h1, 8'h2b, 8'h00, 64'h3000_0100, 16'h0, 16'h0, 10'h051, 7'h04, 16'h0},
    '{4'h2, 8'h20, 8'h00, 64'h0, 16'h0, 16'h0, 10'h004, 7'h04, 16'h0}
  };
  always #2 clk = ~clk;
  txd_decode txd_decode_inst (.clk, .sys_rst, .tx_descriptor, .desc_valid, .desc_ready,
    .fetch_req, .fetch_addr, .fetch_len, .fetch_done, .wb_valid, .wb_status, .wb_ready,
    .writeback_burst_enable, .writeback_irq_enable, .tx_irq_delay_reg, .vlan_ethertype_reg,
    .tx_irq, .irq_delay_running, .desc_bad, .seg_active, .seg_ipv4, .seg_tcp, .seg_snap,
    .csum_ipv4, .csum_tcp, .pkt_start, .pkt_last, .pkt_seg, .vlan_insert_enable,
    .crc_append_enable, .vlan_tag, .vlan_ethertype, .l4_checksum_insert, .ip_checksum_insert);
  txd_host_model txd_host_model_inst (.clk, .sys_rst, .slow, .fetch_req, .fetch_done,
    .wb_valid, .wb_status, .wb_ready, .wb_count, .bad_status);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Registered outputs are sampled mid-cycle, away from the launching edge
  always @(negedge clk) begin
    cyc++;
    if (fetch_req === 1'b1 && !prev_req) begin
      n_fetch++;
      seen_addr = fetch_addr;
      seen_len = fetch_len;
    end
    prev_req = (fetch_req === 1'b1);
    n_irq += int'(tx_irq === 1'b1);
    n_bad += int'(desc_bad === 1'b1);
    n_last += int'(pkt_last === 1'b1);
    n_start += int'(pkt_start === 1'b1);
    if (cyc == 4000) begin
      failures++;
      finish_test();
    end
  end
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [DESC_W-1:0] mk(input logic [3:0] t, input logic [7:0] cmd,
      input logic [7:0] opt, input logic [63:0] adr, input logic [15:0] len,
      input logic [15:0] tag);
    logic [DESC_W-1:0] d;
    d = '0;
    d[ADDR_LSB +: ADDR_W] = adr;
    d[LEN_LSB +: LEN_W] = len;
    d[TYPE_LSB +: TYPE_W] = t;
    d[CMD_LSB +: 8] = cmd;
    d[CMD_LSB + 8 +: 4] = 4'hf;
    d[OPT_LSB +: 8] = opt;
    d[TAG_LSB +: TAG_W] = tag;
    return d;
  endfunction
  // Event counts since mark(): fetch, write-back, irq, bad, last, two bits each
  function automatic logic [9:0] evd();
    int now[5];
    logic [9:0] v;
    now = '{n_fetch, wb_count, n_irq, n_bad, n_last};
    for (int k = 0; k < 5; k++) v[9 - 2 * k -: 2] = 2'(now[k] - snap[k]);
    return v;
  endfunction
  task automatic mark();
    snap = '{n_fetch, wb_count, n_irq, n_bad, n_last};
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 200 && desc_ready !== 1'b1; n++) @(negedge clk);
    cmp("desc_ready", 64'h1, desc_ready);
  endtask
  // Called on a falling edge; the descriptor bus shows its inverse once released
  task automatic put(input logic [DESC_W-1:0] d);
    wait_idle();
    tx_descriptor = d;
    desc_valid = 1'b1;
    @(negedge clk);
    desc_valid = 1'b0;
    tx_descriptor = ~d;
  endtask
  task automatic run(input logic [DESC_W-1:0] d, input int n);
    put(d);
    wait_idle();
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_quiet();
    cmp("quiet outputs", 64'h400, {desc_ready, fetch_req, wb_valid, tx_irq, seg_ipv4, seg_tcp,
      seg_snap, vlan_insert_enable, crc_append_enable, l4_checksum_insert, ip_checksum_insert});
    cmp("quiet tag", 64'h0, vlan_tag);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [DESC_W-1:0] da, dc, df;
    da = mk(TYPE_DATA, 8'ha8, 8'h00, 64'h0, 16'h0, 16'h0);
    dc = mk(TYPE_DATA, 8'h28, 8'h00, 64'h0, 16'h0, 16'h0);
    df = mk(TYPE_DATA, 8'h28, 8'h00, 64'h4000_0000, 16'h80, 16'h0);
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk_quiet();
    sys_rst = 1'b0;
    $display("test reset done");
    foreach (rows[i]) begin
      mark();
      run(mk(rows[i].t, rows[i].cmd, rows[i].opt, rows[i].adr, rows[i].len, rows[i].tag), 3);
      cmp("events", rows[i].ev, evd());
      cmp("controls", rows[i].ctl, {seg_ipv4, seg_tcp, seg_snap, vlan_insert_enable,
        crc_append_enable, l4_checksum_insert, ip_checksum_insert});
      cmp("vlan tag", rows[i].etag, vlan_tag);
      // Ethertype is latched with the first VLAN/CRC sample, which row 3 makes
      cmp("ethertype", (i < 3) ? 16'h0 : vlan_ethertype_reg, vlan_ethertype);
      if (rows[i].ev[9:8] != 2'b00) begin
        cmp("fetch addr", rows[i].adr, seen_addr);
        cmp("fetch len", rows[i].len, seen_len);
      end
      $display("test row %0d done", i);
    end
    cmp("context levels", 64'he, {seg_active, csum_ipv4, csum_tcp, pkt_seg});
    tx_irq_delay_reg = 16'(DLY);
    mark();
    run(da, DLY - 3);
    cmp("delay running", 64'h1, irq_delay_running);
    cmp("delay early", 10'h040, evd());
    repeat (7) @(negedge clk);
    cmp("delay fired", 10'h050, evd());
    $display("test delay done");
    mark();
    run(da, 5);
    run(da, 5);
    cmp("reload early", 10'h080, evd());
    repeat (7) @(negedge clk);
    cmp("reload fired", 10'h090, evd());
    $display("test reload done");
    mark();
    run(da, 2);
    run(dc, 3);
    cmp("immediate", 10'h090, evd());
    cmp("delay cleared", 64'h0, irq_delay_running);
    repeat (DLY + 4) @(negedge clk);
    cmp("no late irq", 10'h090, evd());
    $display("test immediate done");
    writeback_irq_enable = 1'b0;
    mark();
    run(da, DLY + 4);
    run(dc, 3);
    cmp("irq disabled", 10'h080, evd());
    writeback_irq_enable = 1'b1;
    writeback_burst_enable = 1'b1;
    mark();
    put(dc);
    repeat (10) @(negedge clk);
    cmp("burst held", 64'h0, {wb_valid, desc_ready, evd()});
    writeback_burst_enable = 1'b0;
    wait_idle();
    repeat (3) @(negedge clk);
    cmp("burst release", 10'h050, evd());
    $display("test burst done");
    slow = 1'b1;
    mark();
    put(df);
    repeat (3) @(negedge clk);
    cmp("busy", 64'h1, {desc_ready, fetch_req});
    wait_idle();
    repeat (3) @(negedge clk);
    cmp("slow fetch", 10'h150, evd());
    cmp("slow addr", 64'h4000_0000, seen_addr);
    mark();
    put(df);
    repeat (2) @(negedge clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    chk_quiet();
    sys_rst = 1'b0;
    slow = 1'b0;
    run(dc, 3);
    cmp("after reset", 10'h150, evd());
    $display("test stall and reset done");
    cmp("status words", 64'h0, bad_status);
    cmp("packet starts", 64'h7, n_start);
    finish_test();
  end
endmodule
